// ---- common/dfs_pkg.sv ----
package dfs_pkg;
    // Command/address word fields
    localparam int CA_BITS = 48;
    localparam int CA_RW_BIT = 47;
    localparam int CA_SPACE_BIT = 46;
    localparam int CA_BURST_BIT = 45;
    localparam int CA_PAGE_HI = 37;
    localparam int CA_PAGE_LO = 16;
    localparam int CA_WORD_HI = 2;
    localparam int CA_EDGES = 6;
    localparam int CA_PAGE_EDGE = 4;
    localparam int PAGE_W = CA_PAGE_HI - CA_PAGE_LO + 1;
    localparam int WORD_AW = PAGE_W + CA_WORD_HI + 1;
    // Latency codes
    localparam logic [4:0] LAT_BASE = 5'h05;
    localparam logic [3:0] LAT_MAX_CODE = 4'hB;
    localparam logic [3:0] LAT_DEFAULT_CODE = 4'hB;
    // Page geometry in words
    localparam logic [5:0] PAGE_WORDS = 6'h10;
    localparam logic [2:0] SUBPAGE_MASK = 3'h7;
    // Wrap length selections
    localparam logic [1:0] WRAP_16B = 2'h0;
    localparam logic [1:0] WRAP_32B = 2'h1;
    localparam logic [4:0] WMASK_16B = 5'h07;
    localparam logic [4:0] WMASK_32B = 5'h0F;
    localparam logic [4:0] WMASK_64B = 5'h1F;
    localparam logic [15:0] POR_TIMEOUT_RESET = 16'h0000;
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LAT, ST_RDATA, ST_WDATA} dfs_state_type;
endpackage

// ---- core/dfs_fifo.sv ----
`timescale 1ns/1ps
module dfs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff, rp_ff;
    wire push = in_valid_in & in_ready_out;
    wire pop = out_valid_out & out_ready_in;
    // Honest full and empty from pointer comparison
    assign in_ready_out = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
    assign out_valid_out = wp_ff != rp_ff;
    assign out_data_out = mem_ff[rp_ff[AW-1:0]];
    // Pointers
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || flush_in)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            wp_ff <= wp_ff + (AW+1)'(push);
            rp_ff <= rp_ff + (AW+1)'(pop);
        end
    end
    // Storage
    always_ff @(posedge clk_sys_in)
    begin
        if (push)
            mem_ff[wp_ff[AW-1:0]] <= in_data_in;
    end
endmodule // dfs_fifo

// ---- core/dfs_port.sv ----
`timescale 1ns/1ps
module dfs_port
    import dfs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic bus_clk_in,
    input wire logic chip_select_n_in,
    input wire logic hw_reset_n_in,
    input wire logic [7:0] data_lines_in,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe_out,
    output logic read_strobe_out,
    output logic read_strobe_oe_out,
    output logic event_out_n_out,
    output logic event_out_n_oe_out,
    output logic por_reset_out_n_out,
    output logic por_reset_out_n_oe_out,
    input wire logic [3:0] latency_code_in,
    input wire logic [1:0] wrap_len_in,
    input wire logic hybrid_en_in,
    input wire logic event_in,
    input wire logic [15:0] por_timeout_in,
    output logic standby_out,
    output logic mem_open_out,
    output logic [PAGE_W-1:0] mem_page_out,
    output logic mem_req_out,
    output logic [WORD_AW-1:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [15:0] mem_data_in,
    output logic wr_valid_out,
    output logic [WORD_AW-1:0] wr_addr_out,
    output logic [15:0] wr_data_out
);
    initial if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");

    // Two-stage synchronisers for pins
    logic [1:0] ck_sy_ff, cs_sy_ff, hr_sy_ff;
    logic [7:0] dq_sy1_ff, dq_sy2_ff;
    logic ck_d_ff, cs_d_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            ck_sy_ff <= 2'h0;
            cs_sy_ff <= 2'h3;
            hr_sy_ff <= 2'h3;
            dq_sy1_ff <= 8'h00;
            dq_sy2_ff <= 8'h00;
            ck_d_ff <= 1'h0;
            cs_d_ff <= 1'h1;
        end
        else
        begin
            ck_sy_ff <= {ck_sy_ff[0], bus_clk_in};
            cs_sy_ff <= {cs_sy_ff[0], chip_select_n_in};
            hr_sy_ff <= {hr_sy_ff[0], hw_reset_n_in};
            dq_sy1_ff <= data_lines_in;
            dq_sy2_ff <= dq_sy1_ff;
            ck_d_ff <= ck_sy_ff[1];
            cs_d_ff <= cs_sy_ff[1];
        end
    end

    // Edge detection and internal reset
    wire ck_rise = ck_sy_ff[1] & ~ck_d_ff;
    wire ck_fall = ~ck_sy_ff[1] & ck_d_ff;
    wire ck_edge = ck_rise | ck_fall;
    wire cs_open = ~cs_sy_ff[1] & cs_d_ff;
    wire cs_high = cs_sy_ff[1];
    wire hw_rst = ~hr_sy_ff[1];

    // Power-on reset timeout, then standby
    logic [15:0] por_cnt_ff;
    logic por_done_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            por_cnt_ff <= POR_TIMEOUT_RESET;
            por_done_ff <= 1'h0;
        end
        else if (!por_done_ff)
        begin
            por_cnt_ff <= por_cnt_ff + 16'h0001;
            por_done_ff <= por_cnt_ff >= por_timeout_in;
        end
    end
    wire live = por_done_ff & ~hw_rst;
    dfs_state_type st_ff;
    assign por_reset_out_n_out = 1'h0;
    assign por_reset_out_n_oe_out = ~por_done_ff;
    assign standby_out = live & (st_ff == ST_IDLE);

    // Event pin follows internal event
    logic evt_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            evt_ff <= 1'h0;
        else
            evt_ff <= event_in;
    end
    assign event_out_n_out = 1'h0;
    assign event_out_n_oe_out = evt_ff;

    // Decoded command fields and configuration
    logic [CA_BITS-1:0] ca_ff;
    logic [2:0] edge_cnt_ff;
    logic [4:0] lat_cnt_ff, gap_ff;
    wire is_read = ca_ff[CA_RW_BIT];
    wire is_linear = ca_ff[CA_BURST_BIT];
    wire [PAGE_W-1:0] ca_page = ca_ff[CA_PAGE_HI:CA_PAGE_LO];
    wire [2:0] ca_word = ca_ff[CA_WORD_HI:0];
    wire [WORD_AW-1:0] start_addr = {ca_page, ca_word};
    // At the sixth edge the last byte is still on its way in
    wire rd_early = ca_ff[CA_RW_BIT-8];
    wire lin_early = ca_ff[CA_BURST_BIT-8];
    wire [PAGE_W-1:0] page_early = ca_ff[CA_PAGE_HI-8:CA_PAGE_LO-8];
    wire [3:0] lat_code = (latency_code_in > LAT_MAX_CODE) ? LAT_MAX_CODE : latency_code_in;
    wire [4:0] latency = LAT_BASE + {1'h0, lat_code};
    wire [4:0] wmask = (wrap_len_in == WRAP_16B) ? WMASK_16B :
                       (wrap_len_in == WRAP_32B) ? WMASK_32B : WMASK_64B;

    // Page crossing gap: (start & 7) - 16 + latency when positive
    wire [6:0] gap_sum = {4'h0, ca_word & SUBPAGE_MASK} + {2'h0, latency};
    wire gap_pos = gap_sum > {1'h0, PAGE_WORDS};
    wire gap_apply = is_linear | (wmask == WMASK_64B);
    wire [4:0] gap_calc = (gap_pos & gap_apply) ? 5'(gap_sum - {1'h0, PAGE_WORDS}) : 5'h00;
    wire [5:0] first_cross = PAGE_WORDS - {2'h0, ca_ff[CA_PAGE_LO], ca_word};

    // Bus state machine
    logic [5:0] words_out_ff;
    logic hi_phase_ff, crossed_ff;
    wire ca_last = (edge_cnt_ff == 3'(CA_EDGES - 1));
    wire gap_now = ck_rise & ~crossed_ff & (words_out_ff == first_cross) & (gap_ff != 5'h00);
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || !live || cs_high)
            st_ff <= ST_IDLE;
        else if (cs_open)
            st_ff <= ST_CMD;
        else if (st_ff == ST_CMD && ck_edge && ca_last)
            st_ff <= rd_early ? ST_LAT : ST_WDATA;
        else if (st_ff == ST_LAT && ck_rise && lat_cnt_ff == latency)
            st_ff <= ST_RDATA;
    end

    // Command capture, latency and gap counters
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || cs_open)
        begin
            ca_ff <= '0;
            edge_cnt_ff <= 3'h0;
            lat_cnt_ff <= 5'h00;
            gap_ff <= 5'h00;
            crossed_ff <= 1'h0;
        end
        else if (st_ff == ST_CMD && ck_edge)
        begin
            ca_ff <= {ca_ff[CA_BITS-9:0], dq_sy2_ff};
            edge_cnt_ff <= edge_cnt_ff + 3'h1;
        end
        else if (st_ff == ST_LAT && ck_rise)
        begin
            lat_cnt_ff <= lat_cnt_ff + 5'h01;
            gap_ff <= gap_calc;
        end
        else if (st_ff == ST_RDATA && gap_now)
            gap_ff <= gap_ff - 5'h01;
        else if (st_ff == ST_RDATA && ck_rise && words_out_ff == first_cross)
            crossed_ff <= 1'h1;
    end

    // Half-page notice once first two words are in
    wire page_edge = st_ff == ST_CMD && ck_edge && edge_cnt_ff == 3'(CA_PAGE_EDGE - 1);
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            mem_open_out <= 1'h0;
            mem_page_out <= '0;
        end
        else
        begin
            mem_open_out <= page_edge;
            if (page_edge)
                mem_page_out <= {ca_ff[PAGE_W-9:0], dq_sy2_ff};
        end
    end

    // Array prefetch address generator
    logic [WORD_AW-1:0] pf_addr_ff;
    logic [5:0] pf_cnt_ff;
    logic pf_wrap_ff, pf_run_ff;
    wire fifo_in_ready, fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire [WORD_AW-1:0] amask = {{(WORD_AW-5){1'h0}}, wmask};
    wire [WORD_AW-1:0] pf_inc = pf_addr_ff + 1'b1;
    wire [WORD_AW-1:0] pf_wrapped = (pf_addr_ff & ~amask) | (pf_inc & amask);
    wire hyb_switch = hybrid_en_in & pf_wrap_ff & (pf_cnt_ff == {1'h0, wmask});
    wire mem_take = mem_req_out & mem_ack_in;
    assign mem_req_out = pf_run_ff & fifo_in_ready & (st_ff != ST_IDLE);
    assign mem_addr_out = pf_addr_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || st_ff == ST_IDLE)
        begin
            pf_addr_ff <= '0;
            pf_cnt_ff <= 6'h00;
            pf_wrap_ff <= 1'h0;
            pf_run_ff <= 1'h0;
        end
        else if (st_ff == ST_CMD && ck_edge && ca_last)
        begin
            pf_run_ff <= rd_early;
            pf_addr_ff <= {page_early, dq_sy2_ff[2:0]};
            pf_wrap_ff <= ~lin_early;
        end
        else if (mem_take)
        begin
            pf_cnt_ff <= pf_cnt_ff + 6'h01;
            pf_addr_ff <= hyb_switch ? (pf_addr_ff | amask) + 1'b1 :
                          pf_wrap_ff ? pf_wrapped : pf_inc;
            if (hyb_switch)
                pf_wrap_ff <= 1'h0;
        end
    end

    // Word buffer between array and pins
    wire first_rise = st_ff == ST_LAT && ck_rise && lat_cnt_ff == latency;
    wire pop = first_rise | (st_ff == ST_RDATA && ck_rise && !gap_now);
    dfs_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .flush_in(st_ff == ST_IDLE),
        .in_valid_in(mem_take),
        .in_ready_out(fifo_in_ready),
        .in_data_in(mem_data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(pop),
        .out_data_out(fifo_out_data)
    );

    // Read serialiser: strobe toggles with each byte
    logic [7:0] lo_byte_ff;
    logic rs_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || st_ff == ST_IDLE)
        begin
            data_lines_out <= 8'h00;
            lo_byte_ff <= 8'h00;
            rs_ff <= 1'h0;
            words_out_ff <= 6'h00;
            hi_phase_ff <= 1'h0;
        end
        else if (pop && fifo_out_valid)
        begin
            data_lines_out <= fifo_out_data[15:8];
            lo_byte_ff <= fifo_out_data[7:0];
            rs_ff <= ~rs_ff;
            words_out_ff <= words_out_ff + 6'h01;
            hi_phase_ff <= 1'h1;
        end
        else if (st_ff == ST_RDATA && ck_fall && hi_phase_ff)
        begin
            data_lines_out <= lo_byte_ff;
            rs_ff <= ~rs_ff;
            hi_phase_ff <= 1'h0;
        end
    end

    // Pin enables
    logic dq_oe_ff, rs_oe_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || !live || cs_high)
        begin
            dq_oe_ff <= 1'h0;
            rs_oe_ff <= 1'h0;
        end
        else
        begin
            dq_oe_ff <= (st_ff == ST_RDATA) | first_rise;
            rs_oe_ff <= st_ff != ST_IDLE;
        end
    end
    assign data_lines_oe_out = dq_oe_ff;
    assign read_strobe_oe_out = rs_oe_ff;
    assign read_strobe_out = (st_ff == ST_WDATA) ? 1'h0 : rs_ff;

    // Write word capture
    logic [7:0] wr_hi_ff;
    logic wr_first_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || cs_open)
        begin
            wr_valid_out <= 1'h0;
            wr_addr_out <= '0;
            wr_data_out <= 16'h0000;
            wr_hi_ff <= 8'h00;
            wr_first_ff <= 1'h1;
        end
        else
        begin
            wr_valid_out <= st_ff == ST_WDATA && ck_fall;
            if (st_ff == ST_WDATA && ck_rise)
                wr_hi_ff <= dq_sy2_ff;
            if (st_ff == ST_WDATA && ck_fall)
            begin
                wr_data_out <= {wr_hi_ff, dq_sy2_ff};
                wr_addr_out <= wr_first_ff ? start_addr : wr_addr_out + 1'b1;
                wr_first_ff <= 1'h0;
            end
        end
    end
endmodule // dfs_port

// ---- dv/dfs_host_model.sv ----
`timescale 1ns/1ps
module dfs_host_model (
    output logic bus_clk_out,
    output logic chip_select_n_out,
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    input wire logic [7:0] dq_in,
    input wire logic read_strobe_in
);
    logic [15:0] rd_words [$];
    int rises;
    int lat_rises;
    // Parked bus: clock low, deselected
    initial
    begin
        bus_clk_out = 1'b0;
        chip_select_n_out = 1'b1;
        dq_out = 8'h00;
        dq_oe_out = 1'b0;
    end
    // One clock, byte centred on each edge; released lines keep toggling
    task automatic drive_cycle(input logic [15:0] word, input bit drive);
        dq_oe_out = drive;
        dq_out = drive ? word[15:8] : ~dq_out;
        #40 bus_clk_out = 1'b1;
        rises++;
        #40 dq_out = drive ? word[7:0] : ~dq_out;
        #40 bus_clk_out = 1'b0;
        #40;
    endtask
    // Select with clock low, then three command words
    task automatic frame_open(input logic [47:0] ca);
        #3 chip_select_n_out = 1'b0;
        rises = 0;
        #40;
        for (int i = 2; i >= 0; i--)
            drive_cycle(ca[16*i+:16], 1'b1);
    endtask
    // Deselect with clock low, then rest
    task automatic frame_close();
        #40 chip_select_n_out = 1'b1;
        dq_oe_out = 1'b0;
        #200;
    endtask
    // Keep clocking until enough bytes came on strobe edges
    task automatic read_words(input logic [47:0] ca, input int n);
        int got;
        logic [7:0] hi;
        got = 0;
        rd_words.delete();
        frame_open(ca);
        fork
            while (got < 2 * n && rises < 300)
                drive_cycle(16'h0000, 1'b0);
            forever
            begin
                @(read_strobe_in);
                #2;
                if (got == 0)
                    lat_rises = rises - 4;
                if (got % 2 == 1)
                    rd_words.push_back({hi, dq_in});
                else
                    hi = dq_in;
                got++;
            end
        join_any
        disable fork;
        frame_close();
    endtask
endmodule // dfs_host_model

// ---- dv/dfs_port_checker.sv ----
`timescale 1ns/1ps
module dfs_port_checker
    import dfs_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic chip_select_n_in,
    input wire logic hw_reset_n_in,
    input wire logic event_in,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe_out,
    input wire logic read_strobe_out,
    input wire logic read_strobe_oe_out,
    input wire logic event_out_n_oe_out,
    input wire logic por_reset_out_n_oe_out,
    input wire logic standby_out,
    input wire logic mem_req_out,
    input wire logic mem_ack_in,
    input wire logic [WORD_AW-1:0] mem_addr_out,
    input wire logic wr_valid_out
);
    // Single clock domain
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    // Pin timing against causes
    event_follow_a: assert property (##1 event_out_n_oe_out == $past(event_in))
        else $error("event pin lags event");
    por_hold_a: assert property ($rose(rst_n_in) |-> ##[1:2] por_reset_out_n_oe_out [*4]
        ##[1:3] !por_reset_out_n_oe_out) else $error("reset output timing wrong");
    standby_a: assert property (standby_out |-> !por_reset_out_n_oe_out && !data_lines_oe_out)
        else $error("standby while busy");
    cs_float_a: assert property (chip_select_n_in [*6] |-> !data_lines_oe_out && !wr_valid_out
        && !read_strobe_oe_out) else $error("active while deselected");
    hw_float_a: assert property (!hw_reset_n_in [*6] |-> !data_lines_oe_out && !read_strobe_oe_out)
        else $error("driving in hardware reset");
    write_strobe_a: assert property (wr_valid_out |-> read_strobe_oe_out && !read_strobe_out
        && !data_lines_oe_out) else $error("strobe or data wrong in write");
    dq_strobe_a: assert property (data_lines_oe_out && $past(data_lines_oe_out)
        && $changed(data_lines_out) |-> $changed(read_strobe_out)) else $error("byte without strobe");
    mem_hold_a: assert property (mem_req_out && !mem_ack_in |=> $stable(mem_addr_out))
        else $error("request address moved");
endmodule // dfs_port_checker

bind dfs_port dfs_port_checker dfs_port_checker_inst (
    .clk_sys_in, .rst_n_in, .chip_select_n_in, .hw_reset_n_in, .event_in, .data_lines_out,
    .data_lines_oe_out, .read_strobe_out, .read_strobe_oe_out, .event_out_n_oe_out,
    .por_reset_out_n_oe_out, .standby_out, .mem_req_out, .mem_ack_in, .mem_addr_out,
    .wr_valid_out
);

// ---- dv/test_dfs_port.sv ----
`timescale 1ns/1ps
module test_dfs_port;
    import dfs_pkg::*;
    logic clk_sys_in, rst_n_in, hw_reset_n_in, event_in, hybrid_en_in, mem_ack_in;
    logic [3:0] latency_code_in;
    logic [1:0] wrap_len_in;
    logic [15:0] mem_data_in, wr_data_out, wr_data_seen;
    logic bus_clk, cs_n, strobe_wire, mem_open_out, mem_req_out, wr_valid_out, standby_out;
    logic [7:0] host_dq, dq_wire, data_lines_out;
    logic data_lines_oe_out, read_strobe_out, read_strobe_oe_out;
    logic event_out_n_out, event_out_n_oe_out, por_reset_out_n_out, por_reset_out_n_oe_out;
    logic [PAGE_W-1:0] mem_page_out, page_seen;
    logic [WORD_AW-1:0] mem_addr_out, wr_addr_out, wr_addr_seen;
    int wr_cnt = 0;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    // Array content and command words
    function automatic logic [15:0] arr_word(input logic [24:0] a);
        return a[15:0] ^ {7'h00, a[24:16]};
    endfunction
    function automatic logic [47:0] ca_of(input bit rd, input bit lin, input logic [24:0] a);
        return {rd, 1'b0, lin, 7'h00, a[24:3], 13'h0000, a[2:0]};
    endfunction
    // Device wins the data lines; strobe pulled low when released
    assign dq_wire = data_lines_oe_out ? data_lines_out : host_dq;
    assign strobe_wire = read_strobe_oe_out & read_strobe_out;
    assign mem_data_in = arr_word(mem_addr_out);
    dfs_host_model dfs_host_model_inst (
        .bus_clk_out(bus_clk), .chip_select_n_out(cs_n), .dq_out(host_dq), .dq_oe_out(),
        .dq_in(dq_wire), .read_strobe_in(strobe_wire)
    );
    dfs_port dfs_port_inst (
        .clk_sys_in, .rst_n_in, .bus_clk_in(bus_clk), .chip_select_n_in(cs_n), .hw_reset_n_in,
        .data_lines_in(dq_wire), .data_lines_out, .data_lines_oe_out, .read_strobe_out,
        .read_strobe_oe_out, .event_out_n_out, .event_out_n_oe_out, .por_reset_out_n_out,
        .por_reset_out_n_oe_out, .latency_code_in, .wrap_len_in, .hybrid_en_in, .event_in,
        .por_timeout_in(16'h0004), .standby_out, .mem_open_out, .mem_page_out, .mem_req_out,
        .mem_addr_out, .mem_ack_in, .mem_data_in, .wr_valid_out, .wr_addr_out, .wr_data_out
    );
    initial
    begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Slow array, random events, write capture, run limit
    always @(posedge clk_sys_in)
    begin
        mem_ack_in <= 1'($urandom_range(1, 0));
        event_in <= ($urandom_range(7, 0) == 0) ? ~event_in : event_in;
        if (wr_valid_out)
        begin
            wr_cnt <= wr_cnt + 1;
            wr_addr_seen <= wr_addr_out;
            wr_data_seen <= wr_data_out;
        end
        if (mem_open_out)
            page_seen <= mem_page_out;
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            error_cnt++;
            final_report();
        end
    end
    // Read burst against the expected address order
    task automatic do_read(input logic [24:0] s, input int n, input bit lin);
        logic [24:0] m;
        logic [24:0] a;
        int lat;
        m = 25'((wrap_len_in == WRAP_16B) ? WMASK_16B
            : (wrap_len_in == WRAP_32B) ? WMASK_32B : WMASK_64B);
        lat = (latency_code_in > LAT_MAX_CODE) ? 16 : int'(latency_code_in) + int'(LAT_BASE);
        dfs_host_model_inst.read_words(ca_of(1'b1, lin, s), n);
        chk("latency", lat, dfs_host_model_inst.lat_rises);
        chk("words", n, dfs_host_model_inst.rd_words.size());
        chk("page", 32'(s[24:3]), 32'(page_seen));
        for (int k = 0; k < dfs_host_model_inst.rd_words.size(); k++)
        begin
            if (lin)
                a = s + 25'(k);
            else if (hybrid_en_in && k > int'(m))
                a = (s & ~m) + 25'(k);
            else
                a = (s & ~m) | ((s + 25'(k)) & m);
            chk("read word", 32'(arr_word(a)), 32'(dfs_host_model_inst.rd_words[k]));
        end
    endtask
    task automatic do_write(input logic [24:0] a, input logic [15:0] d);
        int n0;
        n0 = wr_cnt;
        dfs_host_model_inst.frame_open(ca_of(1'b0, 1'($urandom_range(1, 0)), a));
        dfs_host_model_inst.drive_cycle(d, 1'b1);
        dfs_host_model_inst.frame_close();
        chk("write count", n0 + 1, wr_cnt);
        chk("write addr", 32'(a), 32'(wr_addr_seen));
        chk("write data", 32'(d), 32'(wr_data_seen));
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(24991));
        {rst_n_in, hw_reset_n_in, event_in, mem_ack_in, hybrid_en_in} = 5'h08;
        latency_code_in = LAT_DEFAULT_CODE;
        wrap_len_in = WRAP_16B;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 chk("reset out", 1, por_reset_out_n_oe_out);
        repeat (12) @(posedge clk_sys_in);
        #1 chk("standby", 1, standby_out);
        for (int c = 0; c < 16; c++)
        begin
            @(posedge clk_sys_in);
            latency_code_in <= 4'(c);
            wrap_len_in <= 2'($urandom_range(3, 0));
            hybrid_en_in <= 1'($urandom_range(1, 0));
            @(posedge clk_sys_in);
            do_read(25'($urandom), $urandom_range(40, 1), 1'($urandom_range(1, 0)));
        end
        @(posedge clk_sys_in);
        {wrap_len_in, hybrid_en_in} <= 3'h5;
        @(posedge clk_sys_in);
        do_read(25'h1FFFFFF, 3, 1'b1);
        do_read(25'h0001237, 20, 1'b1);
        do_read(25'h000013D, 40, 1'b0);
        @(posedge clk_sys_in);
        hw_reset_n_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        hw_reset_n_in <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            repeat (4) @(posedge clk_sys_in);
            do_write(25'($urandom), 16'($urandom));
        end
        final_report();
    end
endmodule // test_dfs_port
